// file: afb_unit.sv
// Purpose: Sixteen-slot function block evaluator
// Assumes: Config and parameter words are synchronous to clock_in
// Notes:   One slot per clock, slot 0 first
`timescale 1ns/100ps
`include "afb_params.svh"
module afb_unit #(
	parameter int unsigned MS_CYCLES = `AFB_MS_CYCLES
) (
	input  wire logic                          clock_in,
	input  wire logic                          reset_in,
	input  wire logic                          cycle_start_in,
	input  wire afb_pkg::afb_slot_cfg_t [15:0] slot_cfg_in,
	input  wire logic [15:0][15:0]             params_in,
	output logic [15:0][15:0]                  block_out_out,
	output logic                               busy_out,
	output logic                               cycle_done_out,
	output logic                               event_valid_out,
	output afb_pkg::afb_event_t                event_out
);
	logic                busy_q, busy_d, done_q, done_d, ev_val_q, ev_val_d;
	logic [3:0]          slot_q, slot_d;
	logic [15:0][15:0]   out_q, out_d, ev_cnt_q, ev_cnt_d;
	logic [15:0]         hyst_q, hyst_d, prev1_q, prev1_d, prev2_q, prev2_d;
	logic [15:0]         ev_pend_q, ev_pend_d, ms_pend_q;
	logic [15:0]         ms_cnt_q, ms_cnt_d;
	logic                ms_tick;
	afb_pkg::afb_event_t ev_q, ev_d;
	afb_pkg::afb_slot_cfg_t cfg;
	logic [15:0]         a, b, c, code, res;
	logic signed [17:0]  sa, sb, sc, sum, thr, pot, lo, step;
	logic [16:0]         abs_a, abs_c;
	logic signed [33:0]  num, quot;
	logic signed [17:0]  den;
	logic                b1, b2, t1, t2, t3, rise1, rise2, gt, eq, lt;
	logic                ev_arm;
	logic [15:0]         ev_left;

	function automatic logic [15:0] pick(input afb_pkg::afb_src_t s);
		logic [15:0] v;
		v = 16'h0000;
		unique case (s.kind)
			afb_pkg::AFB_SRC_NONE:  v = 16'h0000;
			afb_pkg::AFB_SRC_PARAM: v = params_in[s.idx];
			afb_pkg::AFB_SRC_BLOCK: v = out_q[s.idx];
			afb_pkg::AFB_SRC_CONST: v = s.value;
		endcase
		return v;
	endfunction

	function automatic logic [15:0] sat16(input logic signed [33:0] v);
		if (v > `AFB_POS_MAX) begin
			return 16'h7fff;
		end else if (v < `AFB_NEG_MIN) begin
			return 16'h8000;
		end
		return v[15:0];
	endfunction

	// Millisecond time base
	always_comb begin
		ms_tick  = (ms_cnt_q == 16'(MS_CYCLES - 1));
		ms_cnt_d = ms_tick ? 16'h0000 : ms_cnt_q + 16'h0001;
	end

	// Each slot remembers a ms that passed since its last run; set wins
	genvar gi;
	generate
		for (gi = 0; gi < `AFB_SLOTS; gi++) begin : g_ms
			logic pend_d;
			always_comb begin
				pend_d = ms_pend_q[gi];
				if (busy_q && slot_q == 4'(gi)) begin
					pend_d = 1'b0;
				end
				if (ms_tick) begin
					pend_d = 1'b1;
				end
			end
			always_ff @(posedge clock_in or posedge reset_in) begin
				if (reset_in) begin
					ms_pend_q[gi] <= 1'b0;
				end else begin
					ms_pend_q[gi] <= pend_d;
				end
			end
		end
	endgenerate

	// Operand fetch for the running slot
	always_comb begin
		cfg   = slot_cfg_in[slot_q];
		a     = pick(cfg.first_input);
		b     = pick(cfg.second_input);
		c     = pick(cfg.third_input);
		sa    = 18'(signed'(a));
		sb    = 18'(signed'(b));
		sc    = 18'(signed'(c));
		b1    = a[`AFB_TRUE_BIT];
		b2    = b[`AFB_TRUE_BIT];
		t1    = (cfg.first_input.kind == afb_pkg::AFB_SRC_NONE) || b1;
		t2    = (cfg.second_input.kind == afb_pkg::AFB_SRC_NONE) || b2;
		t3    = (cfg.third_input.kind == afb_pkg::AFB_SRC_NONE) || c[`AFB_TRUE_BIT];
		rise1 = b1 && !prev1_q[slot_q];
		rise2 = b2 && !prev2_q[slot_q];
		abs_a = sa[17] ? 17'(-sa) : 17'(sa);
		abs_c = sc[17] ? 17'(-sc) : 17'(sc);
		gt    = sa > sb;
		eq    = sa == sb;
		lt    = sa < sb;
		thr   = sb - sc;
		sum   = sa + sb + sc;
		code  = b;
	end

	// Shared divider: scaling for magnitude mode, ramp step for the pot
	always_comb begin
		if (cfg.op == afb_pkg::AFB_OP_POT) begin
			num = 34'sh0_0000_7fff;
			den = 18'(signed'({1'b0, abs_c}));
		end else begin
			num = 34'(signed'({1'b0, abs_a})) * 34'(sb);
			den = sc;
		end
		quot = (den == 18'sh0_0000) ? 34'sh0_0000_0000 : num / 34'(den);
		step = (abs_c == 17'h00000) ? `AFB_POT_MAX : 18'(quot);
		lo   = sc[17] ? `AFB_POT_NEG : 18'sh0_0000;
	end

	// Slot evaluation
	always_comb begin
		out_d     = out_q;
		hyst_d    = hyst_q;
		prev1_d   = prev1_q;
		prev2_d   = prev2_q;
		ev_pend_d = ev_pend_q;
		ev_cnt_d  = ev_cnt_q;
		ev_val_d  = 1'b0;
		ev_d      = ev_q;
		res       = out_q[slot_q];
		pot       = 18'(signed'(out_q[slot_q]));
		ev_arm    = 1'b0;
		ev_left   = 16'h0000;
		if (busy_q) begin
			prev1_d[slot_q] = b1;
			prev2_d[slot_q] = b2;
			unique case (cfg.op)
				afb_pkg::AFB_OP_NONE: res = out_q[slot_q];
				afb_pkg::AFB_OP_MAG: res = sat16(quot);
				afb_pkg::AFB_OP_ADD: res = sat16(34'(sum));
				afb_pkg::AFB_OP_AND: res = {16{t1 && t2 && t3}};
				afb_pkg::AFB_OP_BITWISE: res = (a | b) & c;
				afb_pkg::AFB_OP_BSET: begin
					res           = a;
					res[b[3:0]]   = c[`AFB_TRUE_BIT];
				end
				afb_pkg::AFB_OP_CMP: begin
					if (gt) begin
						hyst_d[slot_q] = 1'b1;
					end else if (sa < thr) begin
						hyst_d[slot_q] = 1'b0;
					end
					res = {12'h000, hyst_d[slot_q], lt, eq, gt};
				end
				afb_pkg::AFB_OP_COUNT: begin
					if (rise2) begin
						res = 16'h0000;
					end else if (rise1) begin
						if (!sc[17] && sc != 18'sh0_0000) begin
							if (18'(signed'(res)) < sc) begin
								res = res + 16'h0001;
							end
						end else if (sc[17]) begin
							res = (res == 16'h7fff) ? 16'h0000 : res + 16'h0001;
						end
					end
				end
				afb_pkg::AFB_OP_POT: begin
					if (ms_pend_q[slot_q]) begin
						if (b2) begin
							pot = pot - step;
						end else if (b1) begin
							pot = pot + step;
						end
					end
					if (pot > `AFB_POT_MAX) begin
						pot = `AFB_POT_MAX;
					end else if (pot < lo) begin
						pot = lo;
					end
					res = pot[15:0];
				end
				afb_pkg::AFB_OP_EVENT: begin
					res = 16'h0000;
					// Zero delay raises in the triggering evaluation itself
					ev_arm            = rise1 || ev_pend_q[slot_q];
					ev_left           = rise1 ? (sc[17] ? 16'h0000 : c) : ev_cnt_q[slot_q];
					ev_pend_d[slot_q] = ev_arm;
					ev_cnt_d[slot_q]  = ev_left;
					if (!b1) begin
						ev_pend_d[slot_q] = 1'b0;
					end else if (ev_arm) begin
						if (ev_left == 16'h0000) begin
							ev_pend_d[slot_q] = 1'b0;
							ev_d.slot = slot_q;
							ev_d.kind = afb_pkg::AFB_EV_NONE;
							ev_d.num  = 3'h0;
							if (code - `AFB_ALARM_BASE < `AFB_EV_COUNT) begin
								ev_d.kind = afb_pkg::AFB_EV_ALARM;
								ev_d.num  = 3'(code - `AFB_ALARM_BASE + 16'h0001);
							end else if (code - `AFB_FAULT_BASE < `AFB_EV_COUNT) begin
								ev_d.kind = afb_pkg::AFB_EV_FAULT;
								ev_d.num  = 3'(code - `AFB_FAULT_BASE + 16'h0001);
							end else if (code - `AFB_NOTE_BASE < `AFB_EV_COUNT) begin
								ev_d.kind = afb_pkg::AFB_EV_NOTICE;
								ev_d.num  = 3'(code - `AFB_NOTE_BASE + 16'h0001);
							end
							ev_val_d = (ev_d.kind != afb_pkg::AFB_EV_NONE);
						end else if (ms_pend_q[slot_q]) begin
							ev_cnt_d[slot_q] = ev_left - 16'h0001;
						end
					end
				end
				default: res = out_q[slot_q];
			endcase
			out_d[slot_q] = res;
		end
	end

	// Sequencer
	always_comb begin
		busy_d = busy_q;
		slot_d = slot_q;
		done_d = 1'b0;
		if (busy_q) begin
			slot_d = slot_q + 4'h1;
			if (slot_q == `AFB_LAST_SLOT) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end else if (cycle_start_in) begin
			busy_d = 1'b1;
			slot_d = 4'h0;
		end
	end

	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			busy_q    <= 1'b0;
			slot_q    <= 4'h0;
			done_q    <= 1'b0;
			ms_cnt_q  <= 16'h0000;
			out_q     <= '0;
			hyst_q    <= 16'h0000;
			prev1_q   <= 16'h0000;
			prev2_q   <= 16'h0000;
			ev_pend_q <= 16'h0000;
			ev_cnt_q  <= '0;
			ev_val_q  <= 1'b0;
			ev_q      <= '0;
		end else begin
			busy_q    <= busy_d;
			slot_q    <= slot_d;
			done_q    <= done_d;
			ms_cnt_q  <= ms_cnt_d;
			out_q     <= out_d;
			hyst_q    <= hyst_d;
			prev1_q   <= prev1_d;
			prev2_q   <= prev2_d;
			ev_pend_q <= ev_pend_d;
			ev_cnt_q  <= ev_cnt_d;
			ev_val_q  <= ev_val_d;
			ev_q      <= ev_d;
		end
	end

	assign block_out_out   = out_q;
	assign busy_out        = busy_q;
	assign cycle_done_out  = done_q;
	assign event_valid_out = ev_val_q;
	assign event_out       = ev_q;

	// Checking aids: what the last evaluated slot saw
	logic              chk_v_q;
	afb_pkg::afb_op_t  chk_op_q;
	logic [3:0]        chk_s_q;
	logic [15:0]       chk_a_q, chk_b_q, chk_c_q;
	logic signed [17:0] chk_sum_q;
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			chk_v_q   <= 1'b0;
			chk_op_q  <= afb_pkg::AFB_OP_NONE;
			chk_s_q   <= 4'h0;
			chk_a_q   <= 16'h0000;
			chk_b_q   <= 16'h0000;
			chk_c_q   <= 16'h0000;
			chk_sum_q <= 18'sh0_0000;
		end else begin
			chk_v_q   <= busy_q;
			chk_op_q  <= cfg.op;
			chk_s_q   <= slot_q;
			chk_a_q   <= a;
			chk_b_q   <= b;
			chk_c_q   <= c;
			chk_sum_q <= sum;
		end
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in);

	property p_cycle;
		cycle_start_in && !busy_q |=> busy_q [*8] ##1 busy_q [*8] ##1 !busy_q && done_q;
	endproperty
	a_cycle: assert property (p_cycle) else $error("slot sweep not 16 cycles");
	property p_order;
		busy_q && slot_q != `AFB_LAST_SLOT |=> busy_q && slot_q == $past(slot_q) + 4'h1;
	endproperty
	a_order: assert property (p_order) else $error("slot order broken");
	property p_add;
		chk_v_q && chk_op_q == afb_pkg::AFB_OP_ADD && chk_sum_q < 18'sh0_7fff
			&& chk_sum_q > -18'sh0_7fff |-> out_q[chk_s_q] == chk_sum_q[15:0];
	endproperty
	a_add: assert property (p_add) else $error("add result wrong");
	property p_and;
		chk_v_q && chk_op_q == afb_pkg::AFB_OP_AND
			|-> out_q[chk_s_q] == 16'h0000 || out_q[chk_s_q] == 16'hffff;
	endproperty
	a_and: assert property (p_and) else $error("and not all-or-none");
	property p_bitwise;
		chk_v_q && chk_op_q == afb_pkg::AFB_OP_BITWISE
			|-> out_q[chk_s_q] == ((chk_a_q | chk_b_q) & chk_c_q);
	endproperty
	a_bitwise: assert property (p_bitwise) else $error("bitwise wrong");
	property p_bset;
		chk_v_q && chk_op_q == afb_pkg::AFB_OP_BSET
			|-> out_q[chk_s_q][chk_b_q[3:0]] == chk_c_q[0];
	endproperty
	a_bset: assert property (p_bset) else $error("bit not set");
	property p_cmp;
		chk_v_q && chk_op_q == afb_pkg::AFB_OP_CMP |-> out_q[chk_s_q][15:4] == 12'h000
			&& out_q[chk_s_q][0] == (signed'(chk_a_q) > signed'(chk_b_q))
			&& out_q[chk_s_q][2] == (signed'(chk_a_q) < signed'(chk_b_q));
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare bits wrong");
	property p_mag0;
		chk_v_q && chk_op_q == afb_pkg::AFB_OP_MAG && chk_c_q == 16'h0000
			|-> out_q[chk_s_q] == 16'h0000;
	endproperty
	a_mag0: assert property (p_mag0) else $error("zero divisor not zero");
	property p_pot;
		chk_v_q && chk_op_q == afb_pkg::AFB_OP_POT && !chk_c_q[15]
			|-> !out_q[chk_s_q][15];
	endproperty
	a_pot: assert property (p_pot) else $error("pot below zero");
	property p_count_neg;
		chk_v_q && chk_op_q == afb_pkg::AFB_OP_COUNT && chk_c_q[15] |-> !out_q[chk_s_q][15];
	endproperty
	a_count_neg: assert property (p_count_neg) else $error("free count went negative");
	c_cycle: cover property (done_q);
	c_event: cover property (ev_val_q && ev_q.kind == afb_pkg::AFB_EV_FAULT);
	c_hyst: cover property (chk_v_q && chk_op_q == afb_pkg::AFB_OP_CMP && out_q[chk_s_q][3]);
endmodule

// file: afb_params.svh
// Purpose: Constants of the function block unit
// Assumes: 10 MHz clock_in
// Notes:   Definitions only
`ifndef AFB_PARAMS_SVH
`define AFB_PARAMS_SVH
`define AFB_SLOTS      16
`define AFB_LAST_SLOT  4'hf
`define AFB_CLK_KHZ    10000
`define AFB_MS_TIME    1
`define AFB_MS_CYCLES  (`AFB_MS_TIME * `AFB_CLK_KHZ)
`define AFB_POS_MAX    34'sh0_0000_7fff
`define AFB_NEG_MIN    -34'sh0_0000_8000
`define AFB_POT_MAX    18'sh0_7fff
`define AFB_POT_NEG    -18'sh0_7fff
`define AFB_ALARM_BASE 16'h012d
`define AFB_FAULT_BASE 16'h0259
`define AFB_NOTE_BASE  16'h0321
`define AFB_EV_COUNT   16'h0005
`define AFB_TRUE_BIT   0
`endif

// file: afb_pkg.sv
// Purpose: Types of the function block unit
// Assumes: Nothing
// Notes:   Constants live in afb_params.svh
package afb_pkg;
	typedef enum logic [3:0] {
		AFB_OP_NONE    = 4'h0,
		AFB_OP_MAG     = 4'h1,
		AFB_OP_ADD     = 4'h2,
		AFB_OP_AND     = 4'h3,
		AFB_OP_BITWISE = 4'h4,
		AFB_OP_BSET    = 4'h5,
		AFB_OP_CMP     = 4'h6,
		AFB_OP_COUNT   = 4'h7,
		AFB_OP_POT     = 4'h8,
		AFB_OP_EVENT   = 4'h9
	} afb_op_t;
	typedef enum logic [1:0] {
		AFB_SRC_NONE  = 2'h0,
		AFB_SRC_PARAM = 2'h1,
		AFB_SRC_BLOCK = 2'h2,
		AFB_SRC_CONST = 2'h3
	} afb_src_kind_t;
	typedef enum logic [1:0] {
		AFB_EV_NONE   = 2'h0,
		AFB_EV_ALARM  = 2'h1,
		AFB_EV_FAULT  = 2'h2,
		AFB_EV_NOTICE = 2'h3
	} afb_ev_kind_t;
	typedef struct packed {
		afb_src_kind_t kind;
		logic [3:0]    idx;
		logic [15:0]   value;
	} afb_src_t;
	typedef struct packed {
		afb_op_t  op;
		afb_src_t first_input;
		afb_src_t second_input;
		afb_src_t third_input;
	} afb_slot_cfg_t;
	typedef struct packed {
		afb_ev_kind_t kind;
		logic [2:0]   num;
		logic [3:0]   slot;
	} afb_event_t;
endpackage

// file: afb_param_bank.sv
// Purpose: Drive parameter words seen by the function block unit
// Assumes: Bench writes at most one word per clock
// Notes:   Words hold until rewritten, as firmware parameters do
`timescale 1ns/100ps
module afb_param_bank (
	input  wire logic              clock_in,
	input  wire logic              wr_en_in,
	input  wire logic [3:0]        wr_idx_in,
	input  wire logic [15:0]       wr_val_in,
	output logic      [15:0][15:0] params_out
);
	always @(posedge clock_in) begin
		if (wr_en_in) begin
			params_out[wr_idx_in] <= wr_val_in;
		end
	end
endmodule

// file: tb_adaptive_function_block_unit.sv
// Purpose: Self-checking bench of the function block unit
// Assumes: Short millisecond tick of 4 clocks
// Notes:   Each scenario resets the unit first
`timescale 1ns/100ps
module tb_adaptive_function_block_unit;
	localparam afb_pkg::afb_src_kind_t KN = afb_pkg::AFB_SRC_NONE;
	localparam afb_pkg::afb_src_kind_t KP = afb_pkg::AFB_SRC_PARAM;
	localparam afb_pkg::afb_src_kind_t KB = afb_pkg::AFB_SRC_BLOCK;
	localparam afb_pkg::afb_src_kind_t KC = afb_pkg::AFB_SRC_CONST;
	logic                          clock_in;
	logic                          reset_in;
	logic                          cycle_start_in;
	afb_pkg::afb_slot_cfg_t [15:0] cfg;
	logic [15:0][15:0]             params;
	logic [15:0][15:0]             outs;
	logic                          busy;
	logic                          done;
	logic                          ev_valid;
	afb_pkg::afb_event_t           ev;
	logic                          wr_en;
	logic [3:0]                    wr_idx;
	logic [15:0]                   wr_val;
	logic                          ev_seen;
	logic [15:0]                   ev_word;
	int                            fail_count;
	int                            checks_done;

	afb_param_bank bank (.clock_in(clock_in), .wr_en_in(wr_en), .wr_idx_in(wr_idx),
		.wr_val_in(wr_val), .params_out(params));
	afb_unit #(.MS_CYCLES(4)) uut (.clock_in(clock_in), .reset_in(reset_in),
		.cycle_start_in(cycle_start_in), .slot_cfg_in(cfg), .params_in(params),
		.block_out_out(outs), .busy_out(busy), .cycle_done_out(done),
		.event_valid_out(ev_valid), .event_out(ev));

	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic afb_pkg::afb_src_t src(input afb_pkg::afb_src_kind_t k,
		input logic [15:0] v);
		return '{kind: k, idx: v[3:0], value: v};
	endfunction

	task automatic set_slot(input int k, input afb_pkg::afb_op_t op,
		input afb_pkg::afb_src_t a, input afb_pkg::afb_src_t b, input afb_pkg::afb_src_t c);
		@(posedge clock_in);
		cfg[k] <= '{op: op, first_input: a, second_input: b, third_input: c};
	endtask

	task automatic put(input logic [3:0] idx, input logic [15:0] v);
		@(posedge clock_in);
		wr_en <= 1'b1;
		wr_idx <= idx;
		wr_val <= v;
		@(posedge clock_in);
		wr_en <= 1'b0;
	endtask

	task automatic do_reset();
		@(posedge clock_in);
		reset_in <= 1'b1;
		cfg <= '0;
		repeat (4) @(posedge clock_in);
		reset_in <= 1'b0;
	endtask

	// One sweep of all slots, catching any event pulse on the way
	task automatic run_cycle();
		int n;
		ev_seen = 1'b0;
		@(posedge clock_in);
		cycle_start_in <= 1'b1;
		@(posedge clock_in);
		cycle_start_in <= 1'b0;
		#1;
		check("busy", {15'h0000, busy}, 16'h0001);
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			@(posedge clock_in);
			#1;
			n++;
			if (ev_valid === 1'b1) begin
				ev_seen = 1'b1;
				ev_word = {7'h00, ev};
			end
		end
		if (n >= 40) begin
			fail_count++;
			report_and_stop();
		end
	endtask

	task automatic t_arith();
		do_reset();
		for (int k = 0; k < 16; k++) begin
			check("reset out", outs[k], 16'h0000);
		end
		put(4'h0, 16'h0000);
		set_slot(0, afb_pkg::AFB_OP_MAG, src(KC, 16'hfed4), src(KC, 16'h0007), src(KC, 16'h0002));
		set_slot(1, afb_pkg::AFB_OP_ADD, src(KB, 16'h0000), src(KC, 16'h4e20), src(KC, 16'h4e20));
		set_slot(2, afb_pkg::AFB_OP_AND, src(KC, 16'h0001), src(KC, 16'h0001), src(KN, 16'h0000));
		set_slot(3, afb_pkg::AFB_OP_AND, src(KC, 16'h0001), src(KC, 16'h0000), src(KC, 16'h0001));
		set_slot(4, afb_pkg::AFB_OP_BITWISE, src(KC, 16'h5026), src(KC, 16'h1320), src(KC, 16'h4634));
		set_slot(5, afb_pkg::AFB_OP_BSET, src(KP, 16'h0000), src(KC, 16'h000f), src(KC, 16'h0001));
		set_slot(6, afb_pkg::AFB_OP_CMP, src(KB, 16'h0000), src(KC, 16'h03e8), src(KC, 16'h0000));
		set_slot(7, afb_pkg::AFB_OP_MAG, src(KC, 16'h0005), src(KC, 16'h0005), src(KC, 16'h0000));
		set_slot(8, afb_pkg::AFB_OP_ADD, src(KC, 16'h8000), src(KC, 16'hffff), src(KN, 16'h0000));
		set_slot(9, afb_pkg::AFB_OP_ADD, src(KB, 16'h000a), src(KN, 16'h0000), src(KN, 16'h0000));
		set_slot(10, afb_pkg::AFB_OP_ADD, src(KC, 16'h0005), src(KN, 16'h0000), src(KN, 16'h0000));
		run_cycle();
		check("magnitude", outs[0], 16'h041a);
		check("add sat", outs[1], 16'h7fff);
		check("and true", outs[2], 16'hffff);
		check("and false", outs[3], 16'h0000);
		check("bitwise", outs[4], 16'h4224);
		check("bitset", outs[5], 16'h8000);
		check("compare", outs[6], 16'h0009);
		check("zero div", outs[7], 16'h0000);
		check("add neg sat", outs[8], 16'h8000);
		check("old read", outs[9], 16'h0000);
		run_cycle();
		check("new read", outs[9], 16'h0005);
		$display("Test arithmetic done");
	endtask

	task automatic t_compare();
		logic [15:0] in_v [5] = '{16'h0065, 16'h005f, 16'h005a, 16'h0059, 16'h0064};
		logic [15:0] exp_v [5] = '{16'h0009, 16'h000c, 16'h000c, 16'h0004, 16'h0002};
		do_reset();
		set_slot(0, afb_pkg::AFB_OP_CMP, src(KP, 16'h0000), src(KC, 16'h0064), src(KC, 16'h000a));
		for (int i = 0; i < 5; i++) begin
			put(4'h0, in_v[i]);
			run_cycle();
			check("hysteresis", outs[0], exp_v[i]);
		end
		$display("Test compare done");
	endtask

	task automatic t_count();
		do_reset();
		put(4'h0, 16'h0000);
		put(4'h1, 16'h0000);
		set_slot(0, afb_pkg::AFB_OP_COUNT, src(KP, 16'h0000), src(KP, 16'h0001), src(KC, 16'h0003));
		for (int i = 1; i <= 5; i++) begin
			put(4'h0, 16'h0001);
			run_cycle();
			check("count", outs[0], (i > 3) ? 16'h0003 : 16'(i));
			put(4'h0, 16'h0000);
			run_cycle();
		end
		put(4'h1, 16'h0001);
		run_cycle();
		check("count clear", outs[0], 16'h0000);
		set_slot(0, afb_pkg::AFB_OP_COUNT, src(KP, 16'h0000), src(KP, 16'h0001), src(KC, 16'hfffd));
		for (int i = 1; i <= 4; i++) begin
			put(4'h0, 16'h0001);
			run_cycle();
			check("count free", outs[0], 16'(i));
			put(4'h0, 16'h0000);
			run_cycle();
		end
		$display("Test counter done");
	endtask

	task automatic t_pot();
		do_reset();
		put(4'h0, 16'h0001);
		put(4'h1, 16'h0000);
		set_slot(0, afb_pkg::AFB_OP_POT, src(KP, 16'h0000), src(KP, 16'h0001), src(KC, 16'h0002));
		repeat (3) run_cycle();
		check("pot top", outs[0], 16'h7fff);
		put(4'h1, 16'h0001);
		run_cycle();
		check("pot both", outs[0], 16'h4000);
		put(4'h0, 16'h0000);
		repeat (2) run_cycle();
		check("pot floor", outs[0], 16'h0000);
		set_slot(0, afb_pkg::AFB_OP_POT, src(KP, 16'h0000), src(KP, 16'h0001), src(KC, 16'hfffe));
		repeat (3) run_cycle();
		check("pot neg floor", outs[0], 16'h8001);
		$display("Test potentiometer done");
	endtask

	task automatic t_event();
		logic [15:0] code [4] = '{16'h012d, 16'h025a, 16'h0325, 16'h0132};
		logic [15:0] exp_e [4] = '{16'h0091, 16'h0121, 16'h01d1, 16'h0000};
		do_reset();
		for (int i = 0; i < 4; i++) begin
			put(4'h0, 16'h0000);
			set_slot(1, afb_pkg::AFB_OP_EVENT, src(KP, 16'h0000), src(KC, code[i]), src(KC, 16'h0000));
			run_cycle();
			put(4'h0, 16'h0001);
			run_cycle();
			check("event seen", {15'h0000, ev_seen}, {15'h0000, i < 3});
			check("event code", ev_seen ? ev_word : 16'h0000, exp_e[i]);
			run_cycle();
			check("event once", {15'h0000, ev_seen}, 16'h0000);
		end
		check("event out", outs[1], 16'h0000);
		put(4'h0, 16'h0000);
		set_slot(1, afb_pkg::AFB_OP_EVENT, src(KP, 16'h0000), src(KC, 16'h012d), src(KC, 16'h0002));
		run_cycle();
		put(4'h0, 16'h0001);
		run_cycle();
		check("event delayed", {15'h0000, ev_seen}, 16'h0000);
		for (int i = 0; i < 4 && ev_seen !== 1'b1; i++) begin
			run_cycle();
		end
		check("event late", {15'h0000, ev_seen}, 16'h0001);
		$display("Test event done");
	endtask

	initial begin
		reset_in = 1'b1;
		cycle_start_in = 1'b0;
		cfg = '0;
		wr_en = 1'b0;
		wr_idx = 4'h0;
		wr_val = 16'h0000;
		fail_count = 0;
		checks_done = 0;
		repeat (4) @(posedge clock_in);
		reset_in <= 1'b0;
		t_arith();
		t_compare();
		t_count();
		t_pot();
		t_event();
		report_and_stop();
	end
endmodule
